// >>> logic/paur_pkg.sv
package paur_pkg;

   // ----------------------------------------------------------------
   // Configuration offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] CAP_ID_OFFSET     = 12'h100;
   localparam logic [11:0] NEXT_VER_OFFSET   = 12'h102;
   localparam logic [11:0] FLAGS_OFFSET      = 12'h104;
   localparam logic [11:0] SUPPRESS_OFFSET   = 12'h108;
   localparam logic [11:0] SEVERITY_OFFSET   = 12'h10C;

   // ----------------------------------------------------------------
   // Capability header fields
   // ----------------------------------------------------------------
   localparam logic [15:0] CAP_ID_VALUE      = 16'h0001;
   localparam logic [11:0] NEXT_PTR_VALUE    = 12'h000;
   localparam logic [3:0]  CAP_VERSION_VALUE = 4'h1;

   // ----------------------------------------------------------------
   // Error bit positions
   // ----------------------------------------------------------------
   localparam int UNSUPPORTED_REQUEST_POS   = 20;
   localparam int END_TO_END_CRC_POS        = 19;
   localparam int MALFORMED_PACKET_POS      = 18;
   localparam int CREDIT_OVERRUN_POS        = 17;
   localparam int UNEXPECTED_COMPLETION_POS = 16;
   localparam int COMPLETER_ABORT_POS       = 15;
   localparam int COMPLETION_TIMEOUT_POS    = 14;
   localparam int FLOW_CONTROL_PROTOCOL_POS = 13;
   localparam int POISONED_PACKET_POS       = 12;
   localparam int SURPRISE_DOWN_POS         = 5;
   localparam int LINK_PROTOCOL_POS         = 4;

   // ----------------------------------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] IMPLEMENTED_BITS  = 32'h001F_F030;
   localparam logic [31:0] FLAGS_RESET       = 32'h0000_0000;
   localparam logic [31:0] SUPPRESS_RESET    = 32'h0000_0000;
   localparam logic [31:0] SEVERITY_RESET    = 32'h0003_2030;
   localparam logic [31:0] UNDEFINED_BIT0    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [9:0]  dw_addr;
      logic [3:0]  byte_en;
      logic [31:0] wdata;
   } paur_cfg_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } paur_cfg_rsp_t;

   typedef struct packed {
      logic unsupported_request;
      logic end_to_end_crc;
      logic malformed_packet;
      logic credit_overrun;
      logic unexpected_completion;
      logic completer_abort;
      logic completion_timeout;
      logic flow_control_protocol;
      logic poisoned_packet;
      logic surprise_down;
      logic link_protocol;
   } paur_events_t;

   typedef struct packed {
      logic       fatal_msg;
      logic       nonfatal_msg;
      logic       log_valid;
      logic [4:0] log_bit;
   } paur_report_t;

endpackage

// >>> logic/paur_flag_cell.sv
`timescale 1ns/1ps
module paur_flag_cell
(
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic set_evt,
   input  wire logic clr_req,
   output logic      flag
);

   // ----------------------------------------------------------------
   // Sticky flag, set beats clear
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         flag <= 1'b0;
      end
      else
      begin
         flag <= (flag & ~clr_req) | set_evt;
      end
   end

endmodule

// >>> logic/paur_reporter.sv
`timescale 1ns/1ps
module paur_reporter
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic [31:0]           events,
   input  wire logic [31:0]           suppress,
   input  wire logic [31:0]           severity,
   output paur_pkg::paur_report_t     report
);

   logic [31:0] unmasked;
   logic [4:0]  next_log_bit;

   // ----------------------------------------------------------------
   // Masking and severity split
   // ----------------------------------------------------------------
   assign unmasked = events & ~suppress & paur_pkg::IMPLEMENTED_BITS;

   always_comb
   begin
      next_log_bit = 5'd0;
      for (int i = 0; i < 32; i++)
      begin
         if (unmasked[i])
         begin
            next_log_bit = 5'(i);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         report <= '0;
      end
      else
      begin
         report.fatal_msg    <= |(unmasked & severity);
         report.nonfatal_msg <= |(unmasked & ~severity);
         report.log_valid    <= |unmasked;
         report.log_bit      <= next_log_bit;
      end
   end

endmodule

// >>> logic/paur_regs.sv
`timescale 1ns/1ps
module paur_regs
(
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire paur_pkg::paur_cfg_req_t cfg_req,
   input  wire paur_pkg::paur_events_t  err_events,
   output paur_pkg::paur_cfg_rsp_t    cfg_rsp,
   output paur_pkg::paur_report_t     err_report
);

   localparam logic [9:0] HDR_DW  = paur_pkg::CAP_ID_OFFSET[11:2];
   localparam logic [9:0] FLG_DW  = paur_pkg::FLAGS_OFFSET[11:2];
   localparam logic [9:0] SUP_DW  = paur_pkg::SUPPRESS_OFFSET[11:2];
   localparam logic [9:0] SEV_DW  = paur_pkg::SEVERITY_OFFSET[11:2];

   logic [31:0] event_vec;
   logic [31:0] flags;
   logic [31:0] clear_vec;
   logic [31:0] suppress;
   logic [31:0] severity;
   logic [31:0] lane_mask;
   logic [31:0] header_word;
   logic [31:0] next_rdata;
   logic        hit;
   logic        wr_flags;
   logic        wr_suppress;
   logic        wr_severity;

   // ----------------------------------------------------------------
   // Event mapping
   // ----------------------------------------------------------------
   always_comb
   begin
      event_vec = 32'h0000_0000;
      event_vec[paur_pkg::UNSUPPORTED_REQUEST_POS] =
         err_events.unsupported_request;
      event_vec[paur_pkg::END_TO_END_CRC_POS] =
         err_events.end_to_end_crc;
      event_vec[paur_pkg::MALFORMED_PACKET_POS] =
         err_events.malformed_packet;
      event_vec[paur_pkg::CREDIT_OVERRUN_POS] =
         err_events.credit_overrun;
      event_vec[paur_pkg::UNEXPECTED_COMPLETION_POS] =
         err_events.unexpected_completion;
      event_vec[paur_pkg::COMPLETER_ABORT_POS] =
         err_events.completer_abort;
      event_vec[paur_pkg::COMPLETION_TIMEOUT_POS] =
         err_events.completion_timeout;
      event_vec[paur_pkg::FLOW_CONTROL_PROTOCOL_POS] =
         err_events.flow_control_protocol;
      event_vec[paur_pkg::POISONED_PACKET_POS] =
         err_events.poisoned_packet;
      event_vec[paur_pkg::SURPRISE_DOWN_POS] =
         err_events.surprise_down;
      event_vec[paur_pkg::LINK_PROTOCOL_POS] =
         err_events.link_protocol;
   end

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   assign lane_mask = {{8{cfg_req.byte_en[3]}}, {8{cfg_req.byte_en[2]}},
                       {8{cfg_req.byte_en[1]}}, {8{cfg_req.byte_en[0]}}};

   assign hit = cfg_req.valid &&
                (cfg_req.dw_addr == HDR_DW || cfg_req.dw_addr == FLG_DW ||
                 cfg_req.dw_addr == SUP_DW || cfg_req.dw_addr == SEV_DW);

   assign wr_flags    = cfg_req.valid & cfg_req.write &
                        (cfg_req.dw_addr == FLG_DW);
   assign wr_suppress = cfg_req.valid & cfg_req.write &
                        (cfg_req.dw_addr == SUP_DW);
   assign wr_severity = cfg_req.valid & cfg_req.write &
                        (cfg_req.dw_addr == SEV_DW);

   assign clear_vec = wr_flags ?
      (cfg_req.wdata & lane_mask & paur_pkg::IMPLEMENTED_BITS) :
      32'h0000_0000;

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < 32; b++)
      begin : g_flag
         if (paur_pkg::IMPLEMENTED_BITS[b])
         begin : g_impl
            paur_flag_cell u_cell
            (
               .ref_clk (ref_clk),
               .rst     (rst),
               .set_evt (event_vec[b]),
               .clr_req (clear_vec[b]),
               .flag    (flags[b])
            );
         end
         else
         begin : g_rsvd
            assign flags[b] = paur_pkg::UNDEFINED_BIT0[b];
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mask register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         suppress <= paur_pkg::SUPPRESS_RESET;
      end
      else if (wr_suppress)
      begin
         suppress <= ((suppress & ~lane_mask) | (cfg_req.wdata & lane_mask))
                     & paur_pkg::IMPLEMENTED_BITS;
      end
   end

   // ----------------------------------------------------------------
   // Severity register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         severity <= paur_pkg::SEVERITY_RESET;
      end
      else if (wr_severity)
      begin
         severity <= ((severity & ~lane_mask) | (cfg_req.wdata & lane_mask))
                     & paur_pkg::IMPLEMENTED_BITS;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   assign header_word = {paur_pkg::NEXT_PTR_VALUE,
                         paur_pkg::CAP_VERSION_VALUE,
                         paur_pkg::CAP_ID_VALUE};

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (cfg_req.valid && !cfg_req.write)
      begin
         case (cfg_req.dw_addr)
            HDR_DW:  next_rdata = header_word;
            FLG_DW:  next_rdata = flags;
            SUP_DW:  next_rdata = suppress;
            SEV_DW:  next_rdata = severity;
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cfg_rsp <= '0;
      end
      else
      begin
         cfg_rsp.ack   <= hit;
         cfg_rsp.rdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Error reporting
   // ----------------------------------------------------------------
   paur_reporter u_reporter
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .events   (event_vec),
      .suppress (suppress),
      .severity (severity),
      .report   (err_report)
   );

endmodule

// >>> tb/paur_regs_asserts.sv
`timescale 1ns/1ps
module paur_regs_asserts
(
   input wire logic                    ref_clk,
   input wire logic                    rst,
   input wire paur_pkg::paur_cfg_req_t cfg_req,
   input wire paur_pkg::paur_events_t  err_events,
   input wire paur_pkg::paur_cfg_rsp_t cfg_rsp,
   input wire paur_pkg::paur_report_t  err_report
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [31:0] ev;
   logic [31:0] ev_q;
   logic [9:0]  a;
   assign ev = {11'h0, err_events[10:2], 6'h0, err_events[1:0], 4'h0};
   assign a = cfg_req.dw_addr;
   always_ff @(posedge ref_clk)
   begin
      ev_q <= ev;
   end
   // ----
   // Steps
   // ----
   sequence s_rd(logic [9:0] x);
      cfg_req.valid && !cfg_req.write && a == x;
   endsequence
   sequence s_evt;
      ev != 32'h0000_0000;
   endsequence
   sequence s_nowr;
      !(cfg_req.valid && cfg_req.write);
   endsequence
   property p_hdr;
      s_rd(10'h040) |=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0001_0001;
   endproperty
   a_hdr: assert property (p_hdr) else $error("hdr");
   property p_hit;
      cfg_req.valid && a[9:2] == 8'h10 |=> cfg_rsp.ack;
   endproperty
   a_hit: assert property (p_hit) else $error("no ack");
   property p_miss;
      cfg_req.valid && a[9:2] != 8'h10 |=> !cfg_rsp.ack;
   endproperty
   a_miss: assert property (p_miss) else $error("stray ack");
   property p_resv;
      cfg_rsp.ack && $past(a) != 10'h040
         |-> (cfg_rsp.rdata & 32'hFFE0_0FCE) == 32'h0000_0000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved");
   property p_set;
      s_evt ##1 s_nowr ##1 s_rd(10'h041)
         |=> (cfg_rsp.rdata & $past(ev, 3)) == $past(ev, 3);
   endproperty
   a_set: assert property (p_set) else $error("flag");
   property p_log;
      err_report.log_valid |-> ev_q[err_report.log_bit];
   endproperty
   a_log: assert property (p_log) else $error("log bit");
   property p_quiet;
      ev == 32'h0000_0000 |=> err_report == '0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("report");
   property p_kind;
      s_evt |=> err_report.log_valid
         == (err_report.fatal_msg || err_report.nonfatal_msg);
   endproperty
   a_kind: assert property (p_kind) else $error("kind");
endmodule
bind paur_regs paur_regs_asserts u_chk
(
   .ref_clk    (ref_clk),
   .rst        (rst),
   .cfg_req    (cfg_req),
   .err_events (err_events),
   .cfg_rsp    (cfg_rsp),
   .err_report (err_report)
);

// >>> tb/paur_host_model.sv
`timescale 1ns/1ps
module paur_host_model
(
   input  wire logic                    ref_clk,
   input  wire paur_pkg::paur_cfg_rsp_t cfg_rsp,
   output paur_pkg::paur_cfg_req_t      cfg_req
);
   initial cfg_req = '0;
   // One request, answer taken at the edge that samples the ack
   task automatic xfer(input logic w, input logic [9:0] a,
                       input logic [3:0] be, input logic [31:0] d,
                       output logic ack, output logic [31:0] rd);
      @(posedge ref_clk);
      cfg_req <= {1'b1, w, a, be, d};
      @(posedge ref_clk);
      cfg_req <= {1'b0, ~w, ~a, ~be, ~d};
      @(posedge ref_clk);
      ack = cfg_rsp.ack;
      rd = cfg_rsp.rdata;
   endtask
endmodule

// >>> tb/test_paur_regs.sv
`timescale 1ns/1ps
module test_paur_regs;
   logic                    ref_clk = 1'b0;
   logic                    rst = 1'b1;
   paur_pkg::paur_events_t  err_events = '0;
   paur_pkg::paur_cfg_req_t cfg_req;
   paur_pkg::paur_cfg_rsp_t cfg_rsp;
   paur_pkg::paur_report_t  err_report;
   logic [31:0]             flags = '0;
   logic [31:0]             msk = '0;
   logic [31:0]             sev = 32'h0003_2030;
   logic [31:0]             rd;
   logic [10:0]             e;
   logic                    ack;
   integer                  seed = 32'h978f;
   integer                  error_cnt = 0;
   integer                  tests_run = 0;
   integer                  cyc = 0;
   always #25 ref_clk = ~ref_clk;
   paur_regs i_paur_regs
   (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .cfg_req    (cfg_req),
      .err_events (err_events),
      .cfg_rsp    (cfg_rsp),
      .err_report (err_report)
   );
   paur_host_model u_host
   (
      .ref_clk (ref_clk),
      .cfg_rsp (cfg_rsp),
      .cfg_req (cfg_req)
   );
   // ----
   // Helpers
   // ----
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, g);
      tests_run++;
      if (g !== x)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", n, x, g);
      end
   endtask
   function automatic logic [31:0] em(input logic [10:0] v);
      em = {11'h0, v[10:2], 6'h0, v[1:0], 4'h0};
   endfunction
   function automatic logic [31:0] mrd(input logic [9:0] a);
      case (a)
         10'h040: mrd = 32'h0001_0001;
         10'h041: mrd = flags;
         10'h042: mrd = msk;
         default: mrd = sev;
      endcase
   endfunction
   function automatic logic [4:0] hb(input logic [31:0] u);
      hb = 5'h0;
      for (int i = 0; i < 32; i++)
         if (u[i])
            hb = i[4:0];
   endfunction
   task automatic acc(input logic w, input logic [9:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      logic h;
      h = a[9:2] == 8'h10;
      u_host.xfer(w, a, be, d, ack, rd);
      chk("ack", {31'h0, h}, {31'h0, ack});
      if (h)
         chk("rdata", w ? 32'h0 : mrd(a), rd);
   endtask
   task automatic wr(input logic [9:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      acc(1'b1, a, be, d);
      if (a == 10'h041)
         flags = flags & ~(m & d);
      if (a == 10'h042)
         msk = (msk & ~m) | (d & m & paur_pkg::IMPLEMENTED_BITS);
      if (a == 10'h043)
         sev = (sev & ~m) | (d & m & paur_pkg::IMPLEMENTED_BITS);
   endtask
   task automatic evt(input logic [10:0] v);
      logic [31:0] u;
      u = em(v) & ~msk;
      @(posedge ref_clk);
      err_events <= paur_pkg::paur_events_t'(v);
      @(posedge ref_clk);
      err_events <= '0;
      #1;
      flags = flags | em(v);
      chk("report", {24'h0, |(u & sev), |(u & ~sev), |u, hb(u)},
          {24'h0, err_report});
   endtask
   // ----
   // Sequence
   // ----
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      for (int a = 'h40; a < 'h45; a++)
         acc(1'b0, a[9:0], 4'hF, 32'h0);
      for (int i = 0; i < 11; i++)
         evt(11'h001 << i);
      acc(1'b0, 10'h041, 4'hF, 32'h0);
      wr(10'h041, 4'hF, 32'h0);
      acc(1'b0, 10'h041, 4'hF, 32'h0);
      for (int n = 0; n < 20; n++)
      begin
         for (int a = 'h40; a < 'h45; a++)
            wr(a[9:0], 4'($random(seed)), $random(seed));
         e = 11'($random(seed));
         evt(e);
         for (int a = 'h40; a < 'h44; a++)
            acc(1'b0, a[9:0], 4'hF, 32'h0);
      end
      e = 11'($random(seed));
      wr(10'h041, 4'hF, 32'hFFFF_FFFF);
      fork
         u_host.xfer(1'b1, 10'h041, 4'hF, 32'hFFFF_FFFF, ack, rd);
         evt(e);
      join
      chk("ack", 32'h0000_0001, {31'h0, ack});
      flags = em(e);
      acc(1'b0, 10'h041, 4'hF, 32'h0);
      stop_test();
   end
endmodule
